// ---- design/pbsi_top.sv ----
// Parallel bus slave interface: address latch, decoder, reply and interrupts
// Functional notes
// - Latch address when sync asserts
// - Decoder enabled only by data strobes
// - Decode bits 1,2 plus user bits
// - Reply after short delay on decode
// - OR both requests onto bus request
// - Acknowledge latches request, raises vector gate
// - Vector gate drives vector, asserts reply
// - Sync negation returns logic to idle
// - User sets or clears requests anytime
// - Preset and per-channel clear inputs
// - Output strobe low while data reply
// - Block ack downstream while request stored
// - Initialize clears control logic and requests
`timescale 1ns/10ps
module pbsi_top import pbsi_pkg::*; #(
  parameter int unsigned NSEL = NUM_SEL
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Bus control inputs, active low
  input  wire logic              bus_sync_n,
  input  wire logic              data_in_strobe_n,
  input  wire logic              data_out_strobe_n,
  input  wire logic              bank_seven_select_n,
  input  wire logic              write_byte_n,
  input  wire logic              bus_init_n,
  input  wire logic              irq_ack_in_n,
  // Bus data/address in and out, active low, plus active-high output enable
  input  wire logic [BUS_W-1:0]  bus_addr_data_n_i,
  output logic      [BUS_W-1:0]  bus_addr_data_n_o,
  output logic                   bus_addr_data_oe,
  // Bus outputs, active low
  output logic                   bus_reply_n,
  output logic                   bus_irq_n,
  output logic                   irq_ack_out_n,
  // User side data
  input  wire logic [BUS_W-1:0]  driver_inputs,
  output logic      [BUS_W-1:0]  receiver_outputs,
  output logic      [BUS_W-1:0]  addr_q_out,
  // User decode extension and address match
  input  wire logic [1:0]        user_sel_bits,
  input  wire logic              addr_match,
  output logic      [NSEL-1:0]   func_sel_n,
  output logic                   out_data_strobe_n,
  output logic                   read_cycle,
  output logic                   write_cycle,
  output logic                   bank_seven,
  output logic                   byte_write,
  // User interrupt controls
  input  wire logic              user_request_a,
  input  wire logic              user_request_b,
  input  wire logic              preset_a,
  input  wire logic              preset_b,
  input  wire logic              clear_a,
  input  wire logic              clear_b,
  output logic                   vector_gate_a,
  output logic                   vector_gate_b
);
  pbsi_state_t      st_q, st_d;          // Transfer state
  logic [BUS_W-1:0] addr_q, addr_d;      // Latched address
  logic [3:0]       dly_q, dly_d;        // Reply delay counter
  logic [NSEL-1:0]  sel_q, sel_d;        // Function selects, active low
  logic             rply_q, rply_d;      // Reply driven
  logic             ods_q, ods_d;        // Output data strobe, active low
  logic             oe_q, oe_d;          // Bus driver enable
  logic [BUS_W-1:0] dout_q, dout_d;      // Bus drive data, active low
  logic             irq_q, irq_d;        // Bus request
  logic             iako_q, iako_d;      // Ack out, active low
  logic             va_q, va_d;          // Vector gate a
  logic             vb_q, vb_d;          // Vector gate b
  logic [BUS_W-1:0] rx_q, rx_d;          // Received data, true sense
  logic             rc_q, wc_q, b7_q, bw_q; // Decoded bus status
  logic             pend_a, pend_b;      // Stored requests
  logic             ack_a, ack_b;        // Latched on acknowledge
  logic             ack_load, ack_end;   // Channel sequencing
  logic             sync, din, dout, iak; // True-sense bus controls
  logic [3:0]       sel_idx;             // Decode index

  assign sync = ~bus_sync_n;
  assign din  = ~data_in_strobe_n;
  assign dout = ~data_out_strobe_n;
  assign iak  = ~irq_ack_in_n;
  assign sel_idx = {user_sel_bits, addr_q[ADDR_HI_BIT], addr_q[ADDR_LO_BIT]};

  // Interrupt acknowledge load when data-in with ack and no sync
  // Only a device holding a request answers; otherwise the ack passes on
  assign ack_load = (st_q == PBSI_IDLE) && din && iak && !sync
                    && (pend_a || pend_b);
  assign ack_end  = (st_q == PBSI_DONE) && !din;

  // Interrupt channel a
  pbsi_irq_chan u_chan_a (
    .clk        (clk),
    .rst        (rst),
    .bus_init_n (bus_init_n),
    .request    (user_request_a),
    .preset     (preset_a),
    .clear      (clear_a),
    .ack_load   (ack_load),
    .ack_end    (ack_end),
    .pending    (pend_a),
    .acked      (ack_a)
  );

  // Interrupt channel b
  pbsi_irq_chan u_chan_b (
    .clk        (clk),
    .rst        (rst),
    .bus_init_n (bus_init_n),
    .request    (user_request_b),
    .preset     (preset_b),
    .clear      (clear_b),
    .ack_load   (ack_load && !pend_a),
    .ack_end    (ack_end),
    .pending    (pend_b),
    .acked      (ack_b)
  );

  // Transfer sequencer next state
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    dly_d  = dly_q;
    sel_d  = sel_q;
    rply_d = 1'b0;
    ods_d  = 1'b1;
    oe_d   = 1'b0;
    dout_d = dout_q;
    va_d   = va_q;
    vb_d   = vb_q;
    rx_d   = rx_q;
    irq_d  = pend_a || pend_b;
    iako_d = ~(iak && !(pend_a || pend_b));
    case (st_q)
      PBSI_IDLE: begin
        sel_d = '1;
        va_d  = 1'b0;
        vb_d  = 1'b0;
        if (sync) begin
          addr_d = ~bus_addr_data_n_i;
          st_d   = PBSI_ADDR;
        end else if (ack_load) begin
          st_d  = PBSI_VWAIT;
          dly_d = REPLY_DLY_CNT;
        end
      end
      PBSI_ADDR: begin
        if (!sync) begin
          st_d = PBSI_IDLE;
        end else if ((din || dout) && addr_match) begin
          st_d  = PBSI_WAIT;
          dly_d = REPLY_DLY_CNT;
          if (sel_idx < 4'(NSEL)) begin
            sel_d = ~(NSEL'(1) << sel_idx);
          end
          if (dout) begin
            rx_d = ~bus_addr_data_n_i;
          end
        end
      end
      PBSI_WAIT: begin
        oe_d   = din;
        dout_d = ~driver_inputs;
        if (!sync) begin
          st_d = PBSI_IDLE;
        end else if (dly_q <= 4'h1) begin
          st_d = PBSI_REPLY;
        end else begin
          dly_d = dly_q - 4'h1;
        end
      end
      PBSI_REPLY: begin
        oe_d   = din;
        dout_d = ~driver_inputs;
        if (din || dout) begin
          rply_d = 1'b1;
          ods_d  = 1'b0;
        end else begin
          st_d  = PBSI_DONE;
          sel_d = '1;
        end
      end
      PBSI_VWAIT: begin
        va_d = ack_a;
        vb_d = ack_b;
        oe_d = 1'b1;
        dout_d = ~driver_inputs;
        if (dly_q <= 4'h1) begin
          st_d = PBSI_VREP;
        end else begin
          dly_d = dly_q - 4'h1;
        end
      end
      PBSI_VREP: begin
        oe_d   = din;
        dout_d = ~driver_inputs;
        if (din) begin
          rply_d = va_q || vb_q;
        end else begin
          st_d = PBSI_DONE;
        end
      end
      PBSI_DONE: begin
        if (!sync && !din) begin
          st_d = PBSI_IDLE;
          va_d = 1'b0;
          vb_d = 1'b0;
        end
      end
      default: begin
        st_d = PBSI_IDLE;
      end
    endcase
    if (!bus_init_n) begin
      st_d  = PBSI_IDLE;
      sel_d = '1;
      va_d  = 1'b0;
      vb_d  = 1'b0;
      rply_d = 1'b0;
      ods_d = 1'b1;
      oe_d  = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= PBSI_IDLE;
      addr_q <= ADDR_RST;
      dly_q  <= 4'h0;
      sel_q  <= '1;
      rply_q <= 1'b0;
      ods_q  <= 1'b1;
      oe_q   <= 1'b0;
      dout_q <= '1;
      irq_q  <= 1'b0;
      iako_q <= 1'b1;
      va_q   <= 1'b0;
      vb_q   <= 1'b0;
      rx_q   <= '0;
      rc_q   <= 1'b0;
      wc_q   <= 1'b0;
      b7_q   <= 1'b0;
      bw_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      dly_q  <= dly_d;
      sel_q  <= sel_d;
      rply_q <= rply_d;
      ods_q  <= ods_d;
      oe_q   <= oe_d;
      dout_q <= dout_d;
      irq_q  <= irq_d;
      iako_q <= iako_d;
      va_q   <= va_d;
      vb_q   <= vb_d;
      rx_q   <= rx_d;
      rc_q   <= din && sync;
      wc_q   <= dout && sync;
      b7_q   <= ~bank_seven_select_n && sync;
      bw_q   <= ~write_byte_n;
    end
  end

  // Outputs straight from flops
  assign bus_reply_n       = ~rply_q;
  assign bus_irq_n         = ~irq_q;
  assign irq_ack_out_n     = iako_q;
  assign bus_addr_data_n_o = dout_q;
  assign bus_addr_data_oe  = oe_q;
  assign receiver_outputs  = rx_q;
  assign addr_q_out        = addr_q;
  assign func_sel_n        = sel_q;
  assign out_data_strobe_n = ods_q;
  assign read_cycle        = rc_q;
  assign write_cycle       = wc_q;
  assign bank_seven        = b7_q;
  assign byte_write        = bw_q;
  assign vector_gate_a     = va_q;
  assign vector_gate_b     = vb_q;

  a_strobe_reply_tie: assert property (@(posedge clk) disable iff (rst)
    !out_data_strobe_n |-> !bus_reply_n)
    else $error("data strobe without reply");
  a_irq_or_req: assert property (@(posedge clk) disable iff (rst)
    (pend_a || pend_b) |=> !bus_irq_n)
    else $error("request not on bus");
  a_ack_blocked: assert property (@(posedge clk) disable iff (rst)
    (pend_a || pend_b) |=> irq_ack_out_n)
    else $error("ack passed while request stored");
  a_addr_capture: assert property (@(posedge clk) disable iff (rst)
    (st_q == PBSI_IDLE && sync && bus_init_n) |=> (addr_q == ~$past(bus_addr_data_n_i)))
    else $error("address not captured");
  a_sel_enable: assert property (@(posedge clk) disable iff (rst)
    (st_q == PBSI_ADDR && !din && !dout) |=> (func_sel_n == $past(func_sel_n)))
    else $error("select changed without strobe");
  a_reply_delay: assert property (@(posedge clk) disable iff (rst)
    (st_q == PBSI_ADDR && $past(st_q) == PBSI_ADDR && (din || dout) && addr_match
     && sync && bus_init_n) |-> bus_reply_n [*3])
    else $error("reply came too soon");
  a_reply_hold: assert property (@(posedge clk) disable iff (rst)
    (!bus_reply_n && st_q == PBSI_REPLY && (din || dout) && bus_init_n) |=> !bus_reply_n)
    else $error("reply dropped while strobe held");
  a_vec_reply: assert property (@(posedge clk) disable iff (rst)
    (st_q == PBSI_VREP && din && (va_q || vb_q) && bus_init_n) |=> !bus_reply_n)
    else $error("vector gate without reply");
  a_init_clear: assert property (@(posedge clk) disable iff (rst)
    !bus_init_n |=> (bus_reply_n && func_sel_n == '1 && !vector_gate_a))
    else $error("init did not clear");
endmodule // pbsi_top

// ---- design/pbsi_pkg.sv ----
// Package with constants for the parallel bus slave interface
package pbsi_pkg;
  // Bus width and select count
  localparam int unsigned BUS_W        = 16;
  localparam int unsigned NUM_SEL      = 10;
  // Address bit positions used by the decoder
  localparam int unsigned ADDR_LO_BIT  = 1;
  localparam int unsigned ADDR_HI_BIT  = 2;
  // Reply delay in ns and derived clock count
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned REPLY_DLY_NS  = 50;
  localparam int unsigned REPLY_DLY_CYC =
    (REPLY_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REPLY_DLY_CNT = 4'(REPLY_DLY_CYC);
  // Reset value of address register
  localparam logic [15:0] ADDR_RST     = 16'h0000;
  // Transfer states
  typedef enum logic [2:0] {
    PBSI_IDLE  = 3'b000,
    PBSI_ADDR  = 3'b001,
    PBSI_WAIT  = 3'b010,
    PBSI_REPLY = 3'b011,
    PBSI_VWAIT = 3'b100,
    PBSI_VREP  = 3'b101,
    PBSI_DONE  = 3'b110
  } pbsi_state_t;
endpackage

// ---- design/pbsi_irq_chan.sv ----
// One interrupt request channel with preset, clear and acknowledge latch
`timescale 1ns/10ps
module pbsi_irq_chan import pbsi_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bus initialize, active low
  input  wire logic bus_init_n,
  // User controls
  input  wire logic request,
  input  wire logic preset,
  input  wire logic clear,
  // Acknowledge sequencing
  input  wire logic ack_load,
  input  wire logic ack_end,
  // Outputs
  output logic      pending,
  output logic      acked
);
  logic pend_q, pend_d;   // Stored request
  logic ack_q,  ack_d;    // Request latched by acknowledge

  // Next state of request and ack latch
  always_comb begin
    pend_d = pend_q;
    ack_d  = ack_q;
    if (clear) begin
      pend_d = 1'b0;
    end
    if (request || preset) begin
      pend_d = 1'b1;                        // Set wins over clear
    end
    if (ack_load && pend_q) begin
      ack_d = 1'b1;
    end
    if (ack_end) begin
      ack_d = 1'b0;
    end
    if (!bus_init_n) begin
      pend_d = 1'b0;
      ack_d  = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      ack_q  <= ack_d;
    end
  end

  assign pending = pend_q;
  assign acked   = ack_q;

  a_preset_sets: assert property (@(posedge clk) disable iff (rst)
    (preset && bus_init_n) |=> pend_q)
    else $error("preset did not set request");
endmodule // pbsi_irq_chan

// ---- sim/pbsi_master.sv ----
// Bus master model: address, data and interrupt acknowledge cycles
`timescale 1ns/10ps
module pbsi_master import pbsi_pkg::*; (
  // Clock and observed bus
  input  wire logic             clk,
  input  wire logic             bus_reply_n,
  input  wire logic [BUS_W-1:0] bus_wire_n,
  // Master drive, active low
  output logic                  bus_sync_n,
  output logic                  data_in_strobe_n,
  output logic                  data_out_strobe_n,
  output logic                  bank_seven_select_n,
  output logic                  write_byte_n,
  output logic                  irq_ack_in_n,
  output logic [BUS_W-1:0]      drive_n
);
  // Released lines sit at the pull-up level
  initial begin
    bus_sync_n = 1'b1;
    data_in_strobe_n = 1'b1;
    data_out_strobe_n = 1'b1;
    bank_seven_select_n = 1'b1;
    write_byte_n = 1'b1;
    irq_ack_in_n = 1'b1;
    drive_n = '1;
  end
  // Bounded wait for reply at a level
  task wait_reply(input logic lvl, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = bus_reply_n === lvl;
    end
  endtask
  // Read or write; slow stretches the address phase
  task xfer(input logic rd, input logic [15:0] addr, input logic [15:0] wd,
            input int slow, output logic [15:0] rdat, output logic ok);
    logic done;
    @(posedge clk);
    drive_n <= ~addr;
    bank_seven_select_n <= addr < 16'he000;
    write_byte_n <= rd;
    bus_sync_n <= 1'b0;
    repeat (slow + 1) @(posedge clk);
    drive_n <= rd ? '1 : ~wd;
    write_byte_n <= 1'b1;
    data_in_strobe_n <= !rd;
    data_out_strobe_n <= rd;
    wait_reply(1'b0, ok);
    rdat = ~bus_wire_n;
    drive_n <= '1;
    data_in_strobe_n <= 1'b1;
    data_out_strobe_n <= 1'b1;
    wait_reply(1'b1, done);
    bus_sync_n <= 1'b1;
    bank_seven_select_n <= 1'b1;
    @(posedge clk);
  endtask
  // Data-in and acknowledge move together
  task ack_level(input logic lvl);
    @(posedge clk);
    data_in_strobe_n <= lvl;
    irq_ack_in_n <= lvl;
  endtask
  // Interrupt acknowledge, vector taken at reply
  task iack(output logic [15:0] vec, output logic ok);
    logic done;
    ack_level(1'b0);
    wait_reply(1'b0, ok);
    vec = ~bus_wire_n;
    data_in_strobe_n <= 1'b1;
    irq_ack_in_n <= 1'b1;
    wait_reply(1'b1, done);
    @(posedge clk);
  endtask
endmodule // pbsi_master

// ---- sim/tb.sv ----
// Testbench for the parallel bus slave interface
`timescale 1ns/10ps
module tb import pbsi_pkg::*;;
  // Bench and user-side signals
  logic clk, rst, bus_init_n, addr_match, early_sel, ods_snap, ako_snap;
  logic user_request_a, user_request_b, preset_a, preset_b, clear_a, clear_b;
  logic [1:0]         user_sel_bits, vg_snap;
  logic [BUS_W-1:0]   driver_inputs, drive_n, bus_addr_data_n_o, receiver_outputs, addr_q_out;
  logic bus_sync_n, data_in_strobe_n, data_out_strobe_n, bank_seven_select_n, write_byte_n;
  logic irq_ack_in_n, bus_addr_data_oe, bus_reply_n, bus_irq_n, irq_ack_out_n;
  logic out_data_strobe_n, vector_gate_a, vector_gate_b;
  logic read_cycle, write_cycle, bank_seven, byte_write, bw_seen;
  logic [2:0]         stat_snap;
  logic [NUM_SEL-1:0] func_sel_n, sel_snap;
  wire  [BUS_W-1:0]   bus_wire_n;
  int                 mismatches, checked, cycles;
  // Wired bus: both drivers pull low, pull-up otherwise
  assign bus_wire_n = drive_n & (bus_addr_data_oe ? bus_addr_data_n_o : '1);
  pbsi_top i_pbsi_top (
    .clk, .rst, .bus_sync_n, .data_in_strobe_n, .data_out_strobe_n, .bank_seven_select_n,
    .write_byte_n, .bus_init_n, .irq_ack_in_n, .bus_addr_data_n_i(bus_wire_n),
    .bus_addr_data_n_o, .bus_addr_data_oe, .bus_reply_n, .bus_irq_n, .irq_ack_out_n,
    .driver_inputs, .receiver_outputs, .addr_q_out, .user_sel_bits, .addr_match,
    .func_sel_n, .out_data_strobe_n, .read_cycle, .write_cycle, .bank_seven,
    .byte_write, .user_request_a, .user_request_b, .preset_a, .preset_b, .clear_a,
    .clear_b, .vector_gate_a, .vector_gate_b);
  pbsi_master i_pbsi_master (
    .clk, .bus_reply_n, .bus_wire_n, .bus_sync_n, .data_in_strobe_n, .data_out_strobe_n,
    .bank_seven_select_n, .write_byte_n, .irq_ack_in_n, .drive_n);
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task close_out();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Timeout, reply-time snapshots, select before strobe
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
    if (!bus_reply_n) begin
      sel_snap <= func_sel_n;
      ods_snap <= out_data_strobe_n;
      vg_snap <= {vector_gate_b, vector_gate_a};
      ako_snap <= irq_ack_out_n;
      stat_snap <= {read_cycle, write_cycle, bank_seven};
    end
    if (byte_write) bw_seen <= 1'b1;
    if (!bus_sync_n && data_in_strobe_n && data_out_strobe_n && bus_reply_n
        && func_sel_n !== '1) early_sel <= 1'b1;
  end
  // Read at a bank-seven address, slow address phase
  task t_read();
    logic [15:0] rd;
    logic ok;
    driver_inputs <= 16'h5aa5;
    sel_snap = '1;
    i_pbsi_master.xfer(1'b1, 16'he00a, 16'h0000, 3, rd, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(rd, 16'h5aa5);
    chk(16'(sel_snap), 16'h03fd);
    chk({15'h0, ods_snap}, 16'h0000);
    chk(addr_q_out, 16'he00a);
    chk({5'h0, bus_reply_n, func_sel_n}, 16'h07ff);
    chk({15'h0, early_sel}, 16'h0000);
    chk({13'h0, stat_snap}, 16'h0005);
    chk({15'h0, bw_seen}, 16'h0000);
  endtask
  // Writes through every select code, extended by user bits
  task t_write();
    logic [15:0] rd, d;
    logic ok;
    for (int i = 0; i < 16; i++) begin
      d = 16'h3c00 + 16'(i);
      user_sel_bits <= i[3:2];
      sel_snap = '1;
      i_pbsi_master.xfer(1'b0, {13'h0100, i[1:0], 1'b0}, d, i % 2, rd, ok);
      chk(16'(sel_snap), {6'h00, ~(10'h001 << i)});
      if (i < NUM_SEL) begin
        chk({15'h0, ok}, 16'h0001);
        chk(receiver_outputs, d);
      end
    end
    chk({13'h0, stat_snap}, 16'h0002);
    chk({15'h0, bw_seen}, 16'h0001);
  endtask
  // Unrecognised address gets no reply
  task t_refuse();
    logic [15:0] rd;
    logic ok;
    addr_match <= 1'b0;
    i_pbsi_master.xfer(1'b1, 16'h0002, 16'h0000, 0, rd, ok);
    chk({15'h0, ok}, 16'h0000);
    addr_match <= 1'b1;
  endtask
  // Both request channels: set, acknowledge, clear
  task t_irq();
    logic [15:0] v;
    logic ok;
    i_pbsi_master.ack_level(1'b0);
    repeat (3) @(posedge clk);
    chk({15'h0, irq_ack_out_n}, 16'h0000);
    chk({15'h0, bus_addr_data_oe}, 16'h0000);
    i_pbsi_master.ack_level(1'b1);
    repeat (2) @(posedge clk);
    user_request_a <= 1'b1;
    @(posedge clk);
    user_request_a <= 1'b0;
    driver_inputs <= 16'h0104;
    repeat (3) @(posedge clk);
    chk({15'h0, bus_irq_n}, 16'h0000);
    i_pbsi_master.iack(v, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(v, 16'h0104);
    chk({14'h0, vg_snap}, 16'h0001);
    chk({15'h0, ako_snap}, 16'h0001);
    clear_a <= 1'b1;
    @(posedge clk);
    clear_a <= 1'b0;
    preset_b <= 1'b1;
    @(posedge clk);
    preset_b <= 1'b0;
    driver_inputs <= 16'h0108;
    repeat (3) @(posedge clk);
    chk({15'h0, bus_irq_n}, 16'h0000);
    i_pbsi_master.iack(v, ok);
    chk(v, 16'h0108);
    chk({14'h0, vg_snap}, 16'h0002);
    clear_b <= 1'b1;
    @(posedge clk);
    clear_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0, bus_irq_n}, 16'h0001);
  endtask
  // Bus initialize drops a pending request
  task t_init();
    preset_a <= 1'b1;
    @(posedge clk);
    preset_a <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0, bus_irq_n}, 16'h0000);
    bus_init_n <= 1'b0;
    repeat (2) @(posedge clk);
    bus_init_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0, bus_irq_n}, 16'h0001);
  endtask
  // Main sequence
  initial begin
    {rst, bus_init_n, addr_match} = 3'h7;
    {user_request_a, user_request_b, preset_a, preset_b, clear_a, clear_b} = 6'h00;
    {user_sel_bits, driver_inputs, early_sel, bw_seen} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_read();
    t_write();
    t_refuse();
    t_irq();
    t_init();
    close_out();
  end
endmodule // tb
